// ==== logic/tfc_pkg.sv ====
// package for the timer compare channel block: register indices, field
// positions, reset values and output action codes.
// assumes a 32-bit ahb-lite bus with one register per aligned word.
package tfc_pkg;

    // ========================================================
    // register indices, byte address is four times the index
    // ========================================================
    localparam logic [9:0] TFC_IDX_CTL0 = 10'h0ec;
    localparam logic [9:0] TFC_IDX_CMP0 = 10'h0ed;
    localparam logic [9:0] TFC_IDX_CTL1 = 10'h0ee;
    localparam logic [9:0] TFC_IDX_CMP1 = 10'h0ef;
    localparam logic [9:0] TFC_IDX_PEND = 10'h0f0;
    localparam logic [9:0] TFC_IDX_ISTAT = 10'h0f1;
    localparam logic [9:0] TFC_IDX_IMASK = 10'h0f2;

    // ========================================================
    // control register fields
    // ========================================================
    localparam int TFC_CTL_IM_BIT = 6;
    localparam int TFC_CTL_ACT_LSB = 3;
    localparam int TFC_CTL_ACT_MSB = 5;
    localparam int TFC_CTL_EN_BIT = 2;
    localparam logic [7:0] TFC_CTL_WMASK = 8'h7c;
    localparam logic [7:0] TFC_CTL_RESET = 8'h40;
    localparam logic [7:0] TFC_CMP_RESET = 8'h00;
    localparam logic [1:0] TFC_IRQ_RESET = 2'h0;
    localparam logic [1:0] TFC_MASK_RESET = 2'h3;

    // ========================================================
    // counter landmarks
    // ========================================================
    localparam logic [7:0] TFC_CNT_ZERO = 8'h00;
    localparam logic [7:0] TFC_CNT_MAX = 8'hff;

    // ========================================================
    // output action codes
    // ========================================================
    localparam logic [2:0] TFC_ACT_SET = 3'h0;
    localparam logic [2:0] TFC_ACT_CLR = 3'h1;
    localparam logic [2:0] TFC_ACT_TGL = 3'h2;
    localparam logic [2:0] TFC_ACT_SET_UP = 3'h3;
    localparam logic [2:0] TFC_ACT_CLR_UP = 3'h4;
    localparam logic [2:0] TFC_ACT_SET_ALT = 3'h5;
    localparam logic [2:0] TFC_ACT_CLR_ALT = 3'h6;

    // ahb-lite transfer type and response
    localparam logic [1:0] TFC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TFC_HTRANS_SEQ = 2'h3;
    localparam logic TFC_HRESP_OKAY = 1'b0;

endpackage

// ==== logic/tfc_compare.sv ====
// two compare channels sitting beside an 8-bit timer counter, with an
// ahb-lite register slave, pending flags and one level interrupt.
// assumes the counter, its direction and its mode come from logic on hclk.
`timescale 1ns/10ps

// Summary of operation
// - a channel match counts only when the counter becomes equal to its compare value
// - codes 000, 001, 010 set, clear, toggle the output on match
// - code 011 sets on up match, clears at zero or on down match
// - code 100 clears on up match, sets at zero or on down match
// - channel zero code 101 sets on match, clears at 0xff
// - channel zero code 110 clears on match, sets at 0x00
// - channel one code 101 sets on match, clears on channel zero match
// - channel one code 110 clears on match, sets on channel zero match
// - channel zero control bit 6 is interrupt mask, reset 1, 0 blocks
// - channel zero control bit 2 enables compare, reset 0
// - channel one control bit 2 enables compare, reset 0
// - channel zero compare value, 8-bit rw, reset 0x00, also counter top
// - channel one compare value, 8-bit rw, reset 0x00
// - up/down counting runs 0x00 to channel zero value and back
// - compare event sets pending flag; writing 0 clears, writing 1 ignored
module tfc_compare
    import tfc_pkg::*;
#(
    parameter int NUM_CH = 2
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] timer_count_value,
    input wire logic count_down,
    input wire logic updown_mode,
    output logic [NUM_CH-1:0] chan_out,
    output logic [NUM_CH-1:0] chan_pending_irq,
    output logic irq
);

    // ========================================================
    // register state
    // ========================================================
    logic [7:0] ctl_q [NUM_CH];
    logic [7:0] cmp_q [NUM_CH];
    logic [NUM_CH-1:0] pend_q;
    logic [NUM_CH-1:0] istat_q;
    logic [NUM_CH-1:0] imask_q;
    logic [NUM_CH-1:0] out_q;
    logic [31:0] rdata_q;

    // ahb data-phase bookkeeping
    logic wr_pend_q;
    logic [9:0] wr_idx_q;
    logic [9:0] addr_idx;
    logic xfer;
    logic rd_req;
    logic wr_req;

    // counter tracking for equality edges
    logic [7:0] cnt_prev_q;
    logic cnt_valid_q;
    logic cnt_moved;

    // per channel events
    logic [NUM_CH-1:0] ch_match;
    logic [NUM_CH-1:0] ch_enable;
    logic [NUM_CH-1:0] ch_event;
    logic [NUM_CH-1:0] out_d;
    logic at_zero;
    logic at_max;
    logic ch0_hit;

    // ========================================================
    // ahb-lite slave front end
    // ========================================================
    // zero wait state slave: every transfer completes in one data phase
    assign hreadyout = 1'b1;
    assign hresp = TFC_HRESP_OKAY;
    assign hrdata = rdata_q;

    // address phase qualification, only word transfers are expected
    assign addr_idx = haddr[11:2];
    assign xfer = hsel && hready && (htrans == TFC_HTRANS_NONSEQ || htrans == TFC_HTRANS_SEQ);
    assign rd_req = xfer && !hwrite;
    assign wr_req = xfer && hwrite;

    // remember a write address until its data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 10'h000;
        end
        else
        begin
            wr_pend_q <= wr_req;
            if (wr_req)
            begin
                wr_idx_q <= addr_idx;
            end
        end
    end

    // read data captured in the address phase so hrdata comes from a flop
    // unmapped words read as zero; bit 7 and bits 1:0 of control read zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_req)
        begin
            unique case (addr_idx)
                TFC_IDX_CTL0: rdata_q <= {24'h00_0000, ctl_q[0] & TFC_CTL_WMASK};
                TFC_IDX_CMP0: rdata_q <= {24'h00_0000, cmp_q[0]};
                TFC_IDX_CTL1: rdata_q <= {24'h00_0000, ctl_q[1] & TFC_CTL_WMASK};
                TFC_IDX_CMP1: rdata_q <= {24'h00_0000, cmp_q[1]};
                TFC_IDX_PEND: rdata_q <= {30'h0000_0000, pend_q};
                TFC_IDX_ISTAT: rdata_q <= {30'h0000_0000, istat_q};
                TFC_IDX_IMASK: rdata_q <= {30'h0000_0000, imask_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ========================================================
    // configuration registers
    // ========================================================
    // control: mask resets to 1, enable and action to 0; reserved bits
    // are dropped on write, so a careless write of ones does no harm
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl_q[0] <= TFC_CTL_RESET;
            ctl_q[1] <= TFC_CTL_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_idx_q == TFC_IDX_CTL0)
            begin
                ctl_q[0] <= hwdata[7:0] & TFC_CTL_WMASK;
            end
            if (wr_idx_q == TFC_IDX_CTL1)
            begin
                ctl_q[1] <= hwdata[7:0] & TFC_CTL_WMASK;
            end
        end
    end

    // compare values; channel zero doubles as the counter top value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_q[0] <= TFC_CMP_RESET;
            cmp_q[1] <= TFC_CMP_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_idx_q == TFC_IDX_CMP0)
            begin
                cmp_q[0] <= hwdata[7:0];
            end
            if (wr_idx_q == TFC_IDX_CMP1)
            begin
                cmp_q[1] <= hwdata[7:0];
            end
        end
    end

    // interrupt mask register, same layout as the status register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            imask_q <= TFC_MASK_RESET;
        end
        else if (wr_pend_q && wr_idx_q == TFC_IDX_IMASK)
        begin
            imask_q <= hwdata[NUM_CH-1:0];
        end
    end

    // ========================================================
    // counter edge detection
    // ========================================================
    // a match counts only when the counter moves onto the value, so a
    // suspended counter parked on the compare value fires just once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_prev_q <= TFC_CNT_ZERO;
            cnt_valid_q <= 1'b0;
        end
        else
        begin
            cnt_prev_q <= timer_count_value;
            cnt_valid_q <= 1'b1;
        end
    end

    // counter taking a new value this cycle
    assign cnt_moved = cnt_valid_q && (timer_count_value != cnt_prev_q);
    assign at_zero = cnt_moved && (timer_count_value == TFC_CNT_ZERO);
    assign at_max = cnt_moved && (timer_count_value == TFC_CNT_MAX);
    // channel zero value is also the up/down turning point
    assign ch0_hit = cnt_moved && (timer_count_value == cmp_q[0]);

    // ========================================================
    // per channel compare and output action
    // ========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [2:0] act;
            logic up_hit;
            logic dn_hit;

            assign act = ctl_q[g][TFC_CTL_ACT_MSB:TFC_CTL_ACT_LSB];
            assign ch_enable[g] = ctl_q[g][TFC_CTL_EN_BIT];
            assign ch_match[g] = cnt_moved && (timer_count_value == cmp_q[g]);
            // the unused action code raises no event, so no flag is set
            assign ch_event[g] = ch_enable[g] && ch_match[g] && (act <= TFC_ACT_CLR_ALT);
            // direction decides which half of an up/down period matched
            assign up_hit = ch_event[g] && !(updown_mode && count_down);
            assign dn_hit = ch_event[g] && updown_mode && count_down;

            // the per channel mask in the control register gates the request
            assign chan_pending_irq[g] = pend_q[g] && ctl_q[g][TFC_CTL_IM_BIT];

            // next output value; match actions are placed last so they win
            // when the compare value sits on zero or on the top value
            always_comb
            begin
                out_d[g] = out_q[g];
                if (ch_enable[g])
                begin
                    unique case (act)
                        TFC_ACT_SET: out_d[g] = ch_event[g] ? 1'b1 : out_q[g];
                        TFC_ACT_CLR: out_d[g] = ch_event[g] ? 1'b0 : out_q[g];
                        TFC_ACT_TGL: out_d[g] = ch_event[g] ? !out_q[g] : out_q[g];
                        TFC_ACT_SET_UP:
                        begin
                            if ((!updown_mode && at_zero) || dn_hit)
                                out_d[g] = 1'b0;
                            if (up_hit)
                                out_d[g] = 1'b1;
                        end
                        TFC_ACT_CLR_UP:
                        begin
                            if ((!updown_mode && at_zero) || dn_hit)
                                out_d[g] = 1'b1;
                            if (up_hit)
                                out_d[g] = 1'b0;
                        end
                        TFC_ACT_SET_ALT:
                        begin
                            if (g == 0 ? at_max : ch0_hit)
                                out_d[g] = 1'b0;
                            if (ch_event[g])
                                out_d[g] = 1'b1;
                        end
                        TFC_ACT_CLR_ALT:
                        begin
                            if (g == 0 ? at_zero : ch0_hit)
                                out_d[g] = 1'b1;
                            if (ch_event[g])
                                out_d[g] = 1'b0;
                        end
                        default: out_d[g] = out_q[g];
                    endcase
                end
            end

            // output pin flop; holds while disabled or on the unused code
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    out_q[g] <= 1'b0;
                end
                else
                begin
                    out_q[g] <= out_d[g];
                end
            end
        end
    endgenerate

    assign chan_out = out_q;

    // ========================================================
    // pending flags and interrupt status
    // ========================================================
    // pending flags: written zero clears, written one ignored; a compare
    // event in the same cycle as the clear keeps the flag set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_q <= TFC_IRQ_RESET;
        end
        else
        begin
            if (wr_pend_q && wr_idx_q == TFC_IDX_PEND)
            begin
                pend_q <= (pend_q & hwdata[NUM_CH-1:0]) | ch_event;
            end
            else
            begin
                pend_q <= pend_q | ch_event;
            end
        end
    end

    // sticky status cleared by reading it; the read returns the value
    // before the clear, and a same-cycle event survives the clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            istat_q <= TFC_IRQ_RESET;
        end
        else if (rd_req && addr_idx == TFC_IDX_ISTAT)
        begin
            istat_q <= ch_event;
        end
        else
        begin
            istat_q <= istat_q | ch_event;
        end
    end

    // level interrupt: any status bit passing both masks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= 1'b0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (istat_q[i] && imask_q[i] && ctl_q[i][TFC_CTL_IM_BIT])
                    irq <= 1'b1;
            end
        end
    end

endmodule

// ==== bench/tfc_compare_properties.sv ====
// checker for the compare channel block, watching only its ports.
// assumes it is bound into every tfc_compare instance.
`timescale 1ns/10ps
module tfc_compare_chk
    import tfc_pkg::*;
#(
    parameter int NUM_CH = 2
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] timer_count_value,
    input wire logic count_down,
    input wire logic updown_mode,
    input wire logic [NUM_CH-1:0] chan_out,
    input wire logic [NUM_CH-1:0] chan_pending_irq,
    input wire logic irq
);
    // ==============================
    // helper flags
    // ==============================
    logic take;
    logic rd_bad;
    logic wr_dp_q;
    logic any_dp_q;
    assign take = hsel && hready && htrans[1];
    assign rd_bad = take && !hwrite && (haddr[11:2] < TFC_IDX_CTL0 || haddr[11:2] > TFC_IDX_IMASK);

    // data phase markers: a write only lands at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_dp_q <= 1'b0;
            any_dp_q <= 1'b0;
        end
        else
        begin
            wr_dp_q <= take && hwrite;
            any_dp_q <= take;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==============================
    // assertions
    // ==============================
    chk_bus_okay: assert property (hreadyout && hresp == TFC_HRESP_OKAY)
        else $error("slave stalled or gave an error response");
    chk_unmapped_zero: assert property (rd_bad |=> hrdata == 32'h0)
        else $error("unmapped word did not read zero");
    chk_rdata_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    chk_ctl_spare_zero: assert property (
        take && !hwrite && (haddr[11:2] == TFC_IDX_CTL0 || haddr[11:2] == TFC_IDX_CTL1)
        |=> (hrdata & 32'hffffff83) == 32'h0)
        else $error("control spare bits read nonzero");
    chk_still_holds: assert property ($stable(timer_count_value) |=> $stable(chan_out))
        else $error("output moved while the counter stood still");
    chk_pend_cause: assert property ($changed(chan_pending_irq) |->
        $past(timer_count_value) != $past(timer_count_value, 2) || $past(wr_dp_q))
        else $error("pending flag moved with no event or write");
    chk_irq_rise: assert property ($rose(irq) |->
        $past(timer_count_value, 2) != $past(timer_count_value, 3) || $past(wr_dp_q, 2))
        else $error("interrupt rose with no event or write");
    chk_irq_fall: assert property ($fell(irq) |-> $past(any_dp_q) || $past(any_dp_q, 2))
        else $error("interrupt fell with no bus access");

    cover property ($rose(chan_out[0]));
    cover property ($fell(chan_out[NUM_CH-1]));
    cover property ($rose(irq));
endmodule

bind tfc_compare tfc_compare_chk #(.NUM_CH(NUM_CH)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_count_value(timer_count_value), .count_down(count_down),
    .updown_mode(updown_mode), .chan_out(chan_out), .chan_pending_irq(chan_pending_irq),
    .irq(irq));

// ==== bench/tfc_compare_bench.sv ====
// self-checking bench for the compare channel block.
// assumes the checker is bound in; the bench drives every input itself except hready, which is tied to hreadyout.
`timescale 1ns/10ps
module tfc_compare_bench
    import tfc_pkg::*;
;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] timer_count_value;
    logic count_down;
    logic updown_mode;
    logic [1:0] chan_out;
    logic [1:0] chan_pending_irq;
    logic irq;
    int mismatches;
    int checked;
    integer seed;
    logic [7:0] ctl [2];
    logic [7:0] cmpv [2];
    logic [1:0] exp_out;
    logic [1:0] pend;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [1:0] w;

    tfc_compare #(.NUM_CH(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer_count_value(timer_count_value), .count_down(count_down),
        .updown_mode(updown_mode), .chan_out(chan_out), .chan_pending_irq(chan_pending_irq),
        .irq(irq));

    // 40 mhz clock
    always #12.5 hclk = ~hclk;

    // ==============================
    // compare and bus tasks
    // ==============================
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t pins %b expected %b", $time, got, exp);
        end
    endtask

    // bounded wait, the slave may in principle stretch a phase
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64)
            mismatches++;
    endtask

    task automatic bus_go(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
        output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'h0};
        htrans <= TFC_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rdv = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus_go(idx, 1'b1, d, x);
    endtask

    task automatic chk_rd(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus_go(idx, 1'b0, 32'h0, x);
        cmp_reg(x, exp);
    endtask

    // ==============================
    // reference model of one channel
    // ==============================
    // returns {event, next output}
    function automatic logic [1:0] model(int c, logic o, logic [7:0] p, logic [7:0] v,
        logic dn);
        logic [2:0] m;
        logic dnm;
        logic alt;
        m = ctl[c][5:3];
        dnm = updown_mode && dn;
        if (v == p || !ctl[c][2] || m == 3'h7)
            return {1'b0, o};
        if (v == cmpv[c])
            return {1'b1, m == 3'h0 || m == 3'h5 || (m == 3'h2 && !o) ||
                (m == 3'h3 && !dnm) || (m == 3'h4 && dnm)};
        if (m == 3'h3 || m == 3'h4)
            alt = !updown_mode && v == TFC_CNT_ZERO;
        else if (c == 0)
            alt = v == (m == 3'h5 ? TFC_CNT_MAX : TFC_CNT_ZERO);
        else
            alt = v == cmpv[0];
        return {1'b0, (alt && m > 3'h2) ? (m == 3'h4 || m == 3'h6) : o};
    endfunction

    // counter value biased toward the interesting landmarks
    function automatic logic [7:0] pick();
        logic [2:0] r;
        r = 3'($random(seed));
        if (r < 3'h2)
            return cmpv[0];
        if (r < 3'h4)
            return cmpv[1];
        if (r == 3'h4)
            return TFC_CNT_ZERO;
        if (r == 3'h5)
            return TFC_CNT_MAX;
        return 8'($random(seed));
    endfunction

    // one counter move, then outputs, flags and a cycle later the interrupt
    task automatic step(input logic [7:0] v, input logic dn);
        logic [7:0] p;
        logic [1:0] r;
        p = timer_count_value;
        @(posedge hclk);
        timer_count_value <= v;
        count_down <= dn;
        @(posedge hclk);
        #1;
        for (int c = 0; c < 2; c++)
        begin
            r = model(c, exp_out[c], p, v, dn);
            exp_out[c] = r[0];
            pend[c] = pend[c] | r[1];
            istat[c] = istat[c] | r[1];
        end
        cmp_pin(chan_out, exp_out);
        cmp_pin(chan_pending_irq, pend & {ctl[1][6], ctl[0][6]});
        @(posedge hclk);
        #1;
        cmp_pin({1'b0, irq}, {1'b0, |(istat & imask & {ctl[1][6], ctl[0][6]})});
    endtask

    task automatic complete_run;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog, roughly seventeen times the expected run
    initial
    begin
        repeat (30000) @(posedge hclk);
        mismatches++;
        complete_run;
    end

    // ==============================
    // main sequence
    // ==============================
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        timer_count_value = 8'h00;
        count_down = 1'b0;
        updown_mode = 1'b0;
        seed = 32'h9fcfc836;
        mismatches = 0;
        checked = 0;
        exp_out = 2'h0;
        pend = 2'h0;
        istat = 2'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(TFC_IDX_CTL0, 32'h40);
        chk_rd(TFC_IDX_CMP0, 32'h0);
        chk_rd(TFC_IDX_CTL1, 32'h40);
        chk_rd(TFC_IDX_CMP1, 32'h0);
        chk_rd(TFC_IDX_PEND, 32'h0);
        chk_rd(TFC_IDX_IMASK, 32'h3);
        chk_rd(10'h0f3, 32'h0);
        wr(TFC_IDX_CTL0, 32'hfc);
        wr(10'h000, 32'h0);
        chk_rd(TFC_IDX_CTL0, 32'h7c);
        // every action code on each channel, enabled and disabled
        for (int c = 0; c < 2; c++)
            for (int m = 0; m < 8; m++)
                for (int e = 0; e < 2; e++)
                begin
                    cmpv[0] = 8'($random(seed));
                    cmpv[1] = (m == 5 && 1'($random(seed))) ? cmpv[0] : 8'($random(seed));
                    ctl[1 - c] = 8'($random(seed)) & 8'h7c;
                    ctl[c] = {1'b0, 1'($random(seed)), 3'(m), 1'(e), 2'h0};
                    imask = 2'($random(seed));
                    wr(TFC_IDX_CTL0, {24'h0, ctl[0]});
                    wr(TFC_IDX_CMP0, {24'h0, cmpv[0]});
                    wr(TFC_IDX_CTL1, {24'h0, ctl[1]});
                    wr(TFC_IDX_CMP1, {24'h0, cmpv[1]});
                    wr(TFC_IDX_IMASK, {30'h0, imask});
                    updown_mode <= 1'($random(seed));
                    repeat (12) step(pick(), 1'($random(seed)));
                    chk_rd(TFC_IDX_ISTAT, {30'h0, istat});
                    istat = 2'h0;
                    chk_rd(TFC_IDX_PEND, {30'h0, pend});
                    w = 2'($random(seed));
                    wr(TFC_IDX_PEND, {30'h0, w});
                    pend = pend & w;
                    chk_rd(TFC_IDX_PEND, {30'h0, pend});
                end
        complete_run;
    end
endmodule
